// File: core/hbc_pkg.sv
// Package: constants, register map and timing for the hall commutation controller
package hbc_pkg;
   // Clock and timing
   localparam int CLK_MHZ = 10;
   localparam int PWM_PERIOD_NS = 50000;
   localparam int DEAD_NS = 500;
   localparam int SPEED_WIN_MS = 100;
   localparam int PWM_PERIOD_CYC = (PWM_PERIOD_NS * CLK_MHZ) / 1000;
   localparam int DEAD_CYC_I = (DEAD_NS * CLK_MHZ + 999) / 1000;
   localparam int DEAD_CYC = (DEAD_CYC_I < 1) ? 1 : DEAD_CYC_I;
   localparam int SPEED_WIN_CYC = SPEED_WIN_MS * CLK_MHZ * 1000;
   // Edges per window times this scale equals rpm times pole pairs
   localparam int SPEED_SCALE = 60000 / (6 * SPEED_WIN_MS);
   localparam logic [15:0] DUTY_STEP = 16'h0005;
   // Widths
   localparam int PWM_W = 16;
   localparam int ADC_W = 12;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int WIN_W = 24;
   // Register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_TARGET = 4'h1;
   localparam logic [3:0] REG_POLES = 4'h2;
   localparam logic [3:0] REG_TEMP_SHUT = 4'h3;
   localparam logic [3:0] REG_TEMP_START = 4'h4;
   localparam logic [3:0] REG_VOLT_LIM = 4'h5;
   localparam logic [3:0] REG_CURR_LIM = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;
   localparam logic [3:0] REG_SPEED = 4'h8;
   localparam logic [3:0] REG_DUTY = 4'h9;
   localparam logic [3:0] REG_TEMP = 4'hA;
   localparam logic [3:0] REG_VOLT = 4'hB;
   localparam logic [3:0] REG_CURR = 4'hC;
   // Field positions
   localparam int CTRL_RUN = 0;
   localparam int CTRL_SYNC = 1;
   localparam int ST_OC = 3;
   localparam int ST_TEMP = 4;
   localparam int ST_LIM = 5;
   localparam int ST_STATE = 8;
   // Reset values
   localparam logic [3:0] POLES_RST = 4'h2;
   localparam logic [11:0] TEMP_SHUT_RST = 12'h050;
   localparam logic [11:0] TEMP_START_RST = 12'h032;
   localparam logic [11:0] LIM_RST = 12'hFFF;
   localparam logic [15:0] TARGET_RST = 16'h0000;
   // ADC channel codes
   localparam logic [1:0] ADC_VOLT = 2'h0;
   localparam logic [1:0] ADC_CURR = 2'h1;
   localparam logic [1:0] ADC_TEMP = 2'h2;
   // Phase digit codes
   localparam logic [3:0] DIG_OFF = 4'h0;
   localparam logic [3:0] DIG_HIGH = 4'h1;
   localparam logic [3:0] DIG_LOW = 4'h2;
   localparam logic [3:0] DIG_BOTH = 4'h3;
   // Switch patterns, plain mode then synchronous rectification
   localparam logic [11:0] PP_6 = 12'h120;
   localparam logic [11:0] PP_4 = 12'h021;
   localparam logic [11:0] PP_5 = 12'h201;
   localparam logic [11:0] PP_1 = 12'h210;
   localparam logic [11:0] PP_3 = 12'h012;
   localparam logic [11:0] PP_2 = 12'h102;
   localparam logic [11:0] SP_6 = 12'h320;
   localparam logic [11:0] SP_4 = 12'h023;
   localparam logic [11:0] SP_5 = 12'h203;
   localparam logic [11:0] SP_1 = 12'h230;
   localparam logic [11:0] SP_3 = 12'h032;
   localparam logic [11:0] SP_2 = 12'h102;
   localparam logic [11:0] PAT_OFF = 12'h000;
   // Controller states
   typedef enum logic [2:0] {
      HBC_IDLE = 3'b001,
      HBC_RUN = 3'b010,
      HBC_FAULT = 3'b100
   } hbc_state_e;
endpackage

// File: core/hbc_commutation.sv
// Hall block commutation controller with speed loop and protection
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns
//
// Contract
// - Switch pattern is refreshed whenever the hall code changes while running, in both modes.
// - Hall code is {W,V,U}; forward order is 6,4,5,1,3,2.
// - Plain mode patterns 120,021,201,210,012,102 for codes 6,4,5,1,3,2.
// - Rectifying mode patterns 320,023,203,230,032 and 102 for code 2.
// - High side gates are produced identically in both modes.
// - Rectifying mode modulates both switches of the active phase for every code except 2.
// - Duty is adjusted from the speed error.
// - Duty saturates at full on, never wraps.
// - Speed comes from hall edge rate scaled by pole pairs.
// - Rotor position comes straight from the hall code.
// - Overcurrent is latched and forces all six gates off.
// - Overcurrent stops the motor and ends commutation.
// - Shutdown input is active low.
// - Temperature at or over shutdown level disables all gates.
// - Temperature is a digitised reading compared digitally to a threshold.
// - Voltage, current and temperature readings drive protective stops.
// - Pattern digit: 0 off, 1 high, 2 low, 3 complementary; W is top.
// - Complementary low side conducts apart from dead time.
// - Shutdown threshold defaults to 80 whole degrees.
// - No start while temperature exceeds start level, default 50.
module hbc_commutation
   import hbc_pkg::*;
#(
   parameter int WIN_CYC = SPEED_WIN_CYC,
   parameter int PERIOD_CYC = PWM_PERIOD_CYC
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdata,
   input wire logic [2:0] hallIn,
   input wire logic shutdownN,
   input wire logic adcValid,
   input wire logic [1:0] adcChan,
   input wire logic [ADC_W-1:0] adcData,
   output logic [2:0] gateHigh,
   output logic [2:0] gateLow
);
   localparam logic [PWM_W-1:0] PERIOD = PWM_W'(PERIOD_CYC);
   localparam logic [PWM_W:0] DEAD = (PWM_W+1)'(DEAD_CYC);
   localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WIN_CYC - 1);

   typedef struct packed {
      logic [2:0] hallS1;
      logic [2:0] hallS2;
      logic [2:0] hallPrev;
      logic sdS1;
      logic sdS2;
      logic ocLatch;
      logic tempTrip;
      logic limTrip;
      hbc_state_e state;
      logic [11:0] pattern;
      logic [PWM_W-1:0] pwmCnt;
      logic [PWM_W-1:0] duty;
      logic [WIN_W-1:0] winCnt;
      logic [15:0] edgeCnt;
      logic [15:0] speedMeas;
      logic run;
      logic syncRect;
      logic [15:0] target;
      logic [3:0] poles;
      logic [ADC_W-1:0] tempShut;
      logic [ADC_W-1:0] tempStart;
      logic [ADC_W-1:0] voltLim;
      logic [ADC_W-1:0] currLim;
      logic [ADC_W-1:0] tempVal;
      logic [ADC_W-1:0] voltVal;
      logic [ADC_W-1:0] currVal;
      logic [2:0] gateHi;
      logic [2:0] gateLo;
      logic [DATA_W-1:0] rdata;
   } hbc_regs_s;

   hbc_regs_s st_r;
   hbc_regs_s st_nxt;

   // Hall code to switch pattern, invalid codes give all off
   function automatic logic [11:0] patternOf(input logic [2:0] hall, input logic sync);
      logic [11:0] p;
      p = PAT_OFF;
      case (hall)
         3'h6: p = sync ? SP_6 : PP_6;
         3'h4: p = sync ? SP_4 : PP_4;
         3'h5: p = sync ? SP_5 : PP_5;
         3'h1: p = sync ? SP_1 : PP_1;
         3'h3: p = sync ? SP_3 : PP_3;
         3'h2: p = sync ? SP_2 : PP_2; // Printed value kept for code 2
         default: p = PAT_OFF;
      endcase
      return p;
   endfunction

   // PWM carrier decisions shared by all phases
   logic pwmHi;
   logic pwmLo;
   logic [PWM_W:0] loStart;
   assign loStart = {1'b0, st_r.duty} + DEAD;
   assign pwmHi = st_r.pwmCnt < st_r.duty;
   assign pwmLo = ({1'b0, st_r.pwmCnt} >= loStart) &&
                  ({1'b0, st_r.pwmCnt} < ({1'b0, PERIOD} - DEAD));

   // Speed comparison: edges times scale against rpm times pole pairs
   logic [23:0] measScaled;
   logic [23:0] targetScaled;
   logic [PWM_W:0] dutyUp;
   assign measScaled = 24'(st_r.edgeCnt * 8'(SPEED_SCALE));
   assign targetScaled = 24'(st_r.target * st_r.poles);
   assign dutyUp = {1'b0, st_r.duty} + {1'b0, DUTY_STEP};

   // Next-state logic for the whole block
   always_comb begin
      logic hallEdge;
      logic winEnd;
      logic [3:0] dig;
      hallEdge = 1'b0;
      winEnd = 1'b0;
      dig = DIG_OFF;
      st_nxt = st_r;
      st_nxt.rdata = '0;

      // Pin synchronisers
      st_nxt.hallS1 = hallIn;
      st_nxt.hallS2 = st_r.hallS1;
      st_nxt.hallPrev = st_r.hallS2;
      st_nxt.sdS1 = shutdownN;
      st_nxt.sdS2 = st_r.sdS1;
      // Only moves between valid codes count, so the reset value gives no false edge
      hallEdge = st_r.hallS2 != st_r.hallPrev && st_r.hallS2 != 3'h0 && st_r.hallS2 != 3'h7 &&
                 st_r.hallPrev != 3'h0 && st_r.hallPrev != 3'h7;

      // Overcurrent latch, held until reset
      if (!st_r.sdS2) begin
         st_nxt.ocLatch = 1'b1;
      end

      // Digitised readings
      if (adcValid) begin
         case (adcChan)
            ADC_VOLT: st_nxt.voltVal = adcData;
            ADC_CURR: st_nxt.currVal = adcData;
            ADC_TEMP: st_nxt.tempVal = adcData;
            default: st_nxt.voltVal = st_r.voltVal;
         endcase
      end

      // Register writes; trip clears lose against a new trip below
      if (regWr) begin
         case (regAddr)
            REG_CTRL: begin
               st_nxt.run = regWdata[CTRL_RUN];
               st_nxt.syncRect = regWdata[CTRL_SYNC];
            end
            REG_TARGET: st_nxt.target = regWdata;
            REG_POLES: st_nxt.poles = regWdata[3:0];
            REG_TEMP_SHUT: st_nxt.tempShut = regWdata[ADC_W-1:0];
            REG_TEMP_START: st_nxt.tempStart = regWdata[ADC_W-1:0];
            REG_VOLT_LIM: st_nxt.voltLim = regWdata[ADC_W-1:0];
            REG_CURR_LIM: st_nxt.currLim = regWdata[ADC_W-1:0];
            REG_STATUS: begin
               if (regWdata[ST_TEMP]) begin
                  st_nxt.tempTrip = 1'b0;
               end
               if (regWdata[ST_LIM]) begin
                  st_nxt.limTrip = 1'b0;
               end
            end
            default: st_nxt.run = st_nxt.run;
         endcase
      end

      // Protective trips
      if (st_r.tempVal >= st_r.tempShut) begin
         st_nxt.tempTrip = 1'b1;
      end
      if (st_r.voltVal > st_r.voltLim || st_r.currVal > st_r.currLim) begin
         st_nxt.limTrip = 1'b1;
      end

      // Run control
      case (st_r.state)
         HBC_IDLE: begin
            if (st_r.ocLatch) begin
               st_nxt.state = HBC_FAULT;
            end else if (st_r.run && !st_r.tempTrip && !st_r.limTrip &&
                         st_r.tempVal <= st_r.tempStart) begin
               st_nxt.state = HBC_RUN;
            end
         end
         HBC_RUN: begin
            if (st_r.ocLatch) begin
               st_nxt.state = HBC_FAULT;
            end else if (!st_r.run || st_r.tempTrip || st_r.limTrip) begin
               st_nxt.state = HBC_IDLE;
            end
         end
         HBC_FAULT: st_nxt.state = HBC_FAULT;
         default: st_nxt.state = HBC_IDLE;
      endcase

      // Commutation pattern follows the hall code while running
      if (st_r.state == HBC_RUN) begin
         st_nxt.pattern = patternOf(st_r.hallS2, st_r.syncRect);
      end else begin
         st_nxt.pattern = PAT_OFF;
      end

      // PWM carrier
      st_nxt.pwmCnt = (st_r.pwmCnt >= PERIOD - 16'h0001) ? '0 : st_r.pwmCnt + 16'h0001;

      // Speed window: count hall edges
      winEnd = st_r.winCnt >= WIN_LAST;
      st_nxt.winCnt = winEnd ? '0 : st_r.winCnt + 24'h00_0001;
      if (winEnd) begin
         st_nxt.speedMeas = st_r.edgeCnt;
         st_nxt.edgeCnt = {15'h0000, hallEdge};
      end else if (hallEdge && st_r.edgeCnt != 16'hFFFF) begin
         st_nxt.edgeCnt = st_r.edgeCnt + 16'h0001;
      end

      // Speed loop on duty, saturating at both ends
      if (st_r.state != HBC_RUN) begin
         st_nxt.duty = '0;
      end else if (winEnd) begin
         if (measScaled < targetScaled) begin
            st_nxt.duty = (dutyUp >= {1'b0, PERIOD}) ? PERIOD : dutyUp[PWM_W-1:0];
         end else if (measScaled > targetScaled) begin
            st_nxt.duty = (st_r.duty > DUTY_STEP) ? st_r.duty - DUTY_STEP : '0;
         end
      end

      // Per-phase gate decode of the pattern digits, W in the top digit
      for (int i = 0; i < 3; i++) begin
         dig = st_r.pattern[4*i +: 4];
         st_nxt.gateHi[i] = (dig == DIG_HIGH || dig == DIG_BOTH) && pwmHi;
         st_nxt.gateLo[i] = (dig == DIG_LOW) || (dig == DIG_BOTH && pwmLo);
      end
      // Trips or leaving run silence the gates at once, not one pattern later
      if (st_r.tempTrip || st_r.limTrip || st_r.state != HBC_RUN) begin
         st_nxt.gateHi = 3'h0;
         st_nxt.gateLo = 3'h0;
      end

      // Register reads, answer in the following cycle only
      if (regRd) begin
         case (regAddr)
            REG_CTRL: st_nxt.rdata = {14'h0000, st_r.syncRect, st_r.run};
            REG_TARGET: st_nxt.rdata = st_r.target;
            REG_POLES: st_nxt.rdata = {12'h000, st_r.poles};
            REG_TEMP_SHUT: st_nxt.rdata = {4'h0, st_r.tempShut};
            REG_TEMP_START: st_nxt.rdata = {4'h0, st_r.tempStart};
            REG_VOLT_LIM: st_nxt.rdata = {4'h0, st_r.voltLim};
            REG_CURR_LIM: st_nxt.rdata = {4'h0, st_r.currLim};
            REG_STATUS: st_nxt.rdata = {5'h00, st_r.state, 2'h0, st_r.limTrip,
                                        st_r.tempTrip, st_r.ocLatch, st_r.hallS2};
            REG_SPEED: st_nxt.rdata = st_r.speedMeas;
            REG_DUTY: st_nxt.rdata = st_r.duty;
            REG_TEMP: st_nxt.rdata = {4'h0, st_r.tempVal};
            REG_VOLT: st_nxt.rdata = {4'h0, st_r.voltVal};
            REG_CURR: st_nxt.rdata = {4'h0, st_r.currVal};
            default: st_nxt.rdata = '0;
         endcase
      end
   end

   // State register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
         st_r.hallS1 <= 3'h0;
         st_r.sdS1 <= 1'b1;
         st_r.sdS2 <= 1'b1;
         st_r.state <= HBC_IDLE;
         st_r.poles <= POLES_RST;
         st_r.tempShut <= TEMP_SHUT_RST;
         st_r.tempStart <= TEMP_START_RST;
         st_r.voltLim <= LIM_RST;
         st_r.currLim <= LIM_RST;
         st_r.target <= TARGET_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Gates forced off by the latched overcurrent, past the generator
   assign gateHigh = st_r.gateHi & {3{~st_r.ocLatch}};
   assign gateLow = st_r.gateLo & {3{~st_r.ocLatch}};
   assign regRdata = st_r.rdata;

   // Checks
   sequence seqRunHall(logic [2:0] code, logic sync);
      st_r.state == HBC_RUN && st_r.hallS2 == code && st_r.syncRect == sync;
   endsequence
   sequence seqTempStop;
      st_r.tempTrip && st_r.state == HBC_RUN;
   endsequence

   chk_hall_update: assert property (@(posedge sys_clk) disable iff (!nrst)
      st_r.state == HBC_RUN && $past(st_r.state) == HBC_RUN && $changed(st_r.hallS2) &&
      st_r.hallS2 != 3'h0 && st_r.hallS2 != 3'h7 && $past(st_r.hallS2) != 3'h0 &&
      $past(st_r.hallS2) != 3'h7 |=> st_r.pattern != $past(st_r.pattern))
      else $error("pattern did not follow hall change");
   chk_plain_map: assert property (@(posedge sys_clk) disable iff (!nrst)
      seqRunHall(3'h6, 1'b0) |=> st_r.pattern == 12'h120)
      else $error("plain pattern for code 6 wrong");
   chk_sync_map: assert property (@(posedge sys_clk) disable iff (!nrst)
      seqRunHall(3'h5, 1'b1) |=> st_r.pattern == 12'h203)
      else $error("rectifying pattern for code 5 wrong");
   chk_invalid_off: assert property (@(posedge sys_clk) disable iff (!nrst)
      st_r.hallS2 == 3'h7 |=> st_r.pattern == 12'h000 ##1 (gateHigh | gateLow) == 3'h0)
      else $error("invalid hall code drove gates");
   chk_duty_clamp: assert property (@(posedge sys_clk) disable iff (!nrst)
      st_r.duty <= PERIOD)
      else $error("duty beyond full on");
   chk_oc_gates: assert property (@(posedge sys_clk) disable iff (!nrst)
      st_r.ocLatch |-> gateHigh == 3'h0 && gateLow == 3'h0)
      else $error("gates on during overcurrent");
   chk_oc_stop: assert property (@(posedge sys_clk) disable iff (!nrst)
      st_r.ocLatch |=> st_r.state == HBC_FAULT [*3])
      else $error("overcurrent did not stop the motor");
   chk_sd_low: assert property (@(posedge sys_clk) disable iff (!nrst)
      $fell(shutdownN) ##2 !shutdownN |=> st_r.ocLatch)
      else $error("low shutdown not latched");
   chk_temp_off: assert property (@(posedge sys_clk) disable iff (!nrst)
      seqTempStop |=> st_r.state != HBC_RUN ##1 st_r.gateHi == 3'h0)
      else $error("temperature trip left gates on");
   chk_start_hot: assert property (@(posedge sys_clk) disable iff (!nrst)
      st_r.state == HBC_IDLE && st_r.tempVal > st_r.tempStart |=> st_r.state != HBC_RUN)
      else $error("started above start level");
   chk_no_shoot: assert property (@(posedge sys_clk) disable iff (!nrst)
      (gateHigh & gateLow) == 3'h0)
      else $error("high and low on together");
   chk_idle_off: assert property (@(posedge sys_clk) disable iff (!nrst)
      st_r.state != HBC_RUN |=> st_r.gateHi == 3'h0 && st_r.gateLo == 3'h0)
      else $error("gates on while not running");
endmodule

// File: dv/hbc_motor_model.sv
// Hall sensor and gate driver model facing the commutation controller
`timescale 1ns/1ns
module hbc_motor_model (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic advance,
   input wire logic ovrOn,
   input wire logic [2:0] ovrCode,
   input wire logic ocTrip,
   input wire logic [2:0] gateHigh,
   input wire logic [2:0] gateLow,
   output logic [2:0] hallIn,
   output logic shutdownN,
   output logic shootThrough
);
   // Forward rotation order of hall codes, U in bit 0
   localparam logic [2:0] SEQ [6] = '{3'h6, 3'h4, 3'h5, 3'h1, 3'h3, 3'h2};
   int idx;
   // Rotor moves one sector per pulse; both gates of a leg on is a short
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         idx <= 0;
         shootThrough <= 1'b0;
      end else begin
         if (advance) begin
            idx <= (idx == 5) ? 0 : idx + 1;
         end
         if (|(gateHigh & gateLow)) begin
            shootThrough <= 1'b1;
         end
      end
   end
   // Sensor pins show the rotor sector, or a forced broken code
   assign hallIn = ovrOn ? ovrCode : SEQ[idx];
   // Comparator pulls the line low on overcurrent
   assign shutdownN = ~ocTrip;
endmodule

// File: dv/hbc_commutation_test.sv
// Self-checking testbench for the hall commutation controller
`timescale 1ns/1ns
module hbc_commutation_test
   import hbc_pkg::*;
;
   localparam int PER = 50;
   localparam logic [11:0] PLAIN [6] = '{12'h120, 12'h021, 12'h201, 12'h210, 12'h012, 12'h102};
   localparam logic [11:0] SYNC [6] = '{12'h320, 12'h023, 12'h203, 12'h230, 12'h032, 12'h102};
   localparam logic [3:0] RA [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hF};
   localparam logic [15:0] RV [11] = '{16'h0000, 16'h0000, 16'h0002, 16'h0050, 16'h0032,
      16'h0FFF, 16'h0FFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [ADDR_W-1:0] regAddr = '0;
   logic [DATA_W-1:0] regWdata = '0;
   logic [DATA_W-1:0] regRdata;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [2:0] hallIn;
   logic [2:0] gateHigh;
   logic [2:0] gateLow;
   logic shutdownN;
   logic adcValid = 1'b0;
   logic [1:0] adcChan = 2'h0;
   logic [ADC_W-1:0] adcData = '0;
   logic advance = 1'b0;
   logic ovrOn = 1'b0;
   logic [2:0] ovrCode = 3'h0;
   logic ocTrip = 1'b0;
   logic shootThrough;
   logic [15:0] rd;
   logic [5:0] g;
   int n_fail = 0;
   int checked = 0;
   int cycles = 0;

   // Clock of 100 ns period
   always #50 sys_clk = ~sys_clk;

   hbc_commutation #(.WIN_CYC(200), .PERIOD_CYC(PER)) uut (.sys_clk(sys_clk), .nrst(nrst),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .hallIn(hallIn), .shutdownN(shutdownN), .adcValid(adcValid),
      .adcChan(adcChan), .adcData(adcData), .gateHigh(gateHigh), .gateLow(gateLow));

   hbc_motor_model motor (.sys_clk(sys_clk), .nrst(nrst), .advance(advance), .ovrOn(ovrOn),
      .ovrCode(ovrCode), .ocTrip(ocTrip), .gateHigh(gateHigh), .gateLow(gateLow),
      .hallIn(hallIn), .shutdownN(shutdownN), .shootThrough(shootThrough));

   // Verdict and end of run
   task automatic finish_test();
      if (n_fail == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic regWrite(logic [3:0] a, logic [15:0] d);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic regRead(logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask

   task automatic status(logic [7:0] exp);
      regRead(REG_STATUS, rd);
      check(16'(rd[10:3]), 16'(exp));
   endtask

   task automatic adcSend(logic [1:0] c, logic [11:0] d);
      @(posedge sys_clk);
      adcValid <= 1'b1;
      adcChan <= c;
      adcData <= d;
      @(posedge sys_clk);
      adcValid <= 1'b0;
   endtask

   task automatic step();
      @(posedge sys_clk);
      advance <= 1'b1;
      @(posedge sys_clk);
      advance <= 1'b0;
   endtask

   task automatic spin(int n);
      repeat (n) begin
         step();
         tick(8);
      end
   endtask

   // Collects every gate that switched on during one PWM period
   task automatic observe(output logic [5:0] seen);
      seen = 6'h00;
      repeat (PER) begin
         @(posedge sys_clk);
         #1 seen = seen | {gateHigh, gateLow};
      end
   endtask

   // Digit bit 0 drives the high gate, bit 1 the low gate
   function automatic logic [5:0] gatesOf(logic [11:0] p);
      return {p[8], p[4], p[0], p[9], p[5], p[1]};
   endfunction

   task automatic sweep(bit sync);
      for (int k = 1; k <= 6; k++) begin
         step();
         tick(6);
         observe(g);
         check(16'(g), 16'(gatesOf(sync ? SYNC[k % 6] : PLAIN[k % 6])));
      end
   endtask

   task automatic pulseReset();
      @(posedge sys_clk);
      nrst <= 1'b0;
      tick(8);
      nrst <= 1'b1;
      tick(2);
   endtask

   // Cuts a hung run short
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_fail = n_fail + 1;
         finish_test();
      end
   end

   // Main sequence
   initial begin
      tick(8);
      nrst <= 1'b1;
      tick(2);
      for (int i = 0; i < 11; i++) begin
         regRead(RA[i], rd);
         check(rd, RV[i]);
      end
      regWrite(REG_TARGET, 16'hFFFF);
      adcSend(ADC_TEMP, 12'h019);
      regWrite(REG_CTRL, 16'h0001);
      tick(2);
      status(8'h40);
      tick(600);
      sweep(1'b0);
      regWrite(REG_CTRL, 16'h0003);
      sweep(1'b1);
      check(16'(shootThrough), 16'h0000);
      for (int c = 0; c < 8; c += 7) begin
         @(posedge sys_clk);
         ovrOn <= 1'b1;
         ovrCode <= 3'(c);
         tick(6);
         observe(g);
         check(16'(g), 16'h0000);
         @(posedge sys_clk);
         ovrOn <= 1'b0;
      end
      @(posedge sys_clk);
      ocTrip <= 1'b1;
      tick(5);
      observe(g);
      check(16'(g), 16'h0000);
      @(posedge sys_clk);
      ocTrip <= 1'b0;
      step();
      tick(6);
      observe(g);
      check(16'(g), 16'h0000);
      status(8'h81);
      pulseReset();
      status(8'h20);
      regWrite(REG_TARGET, 16'hFFFF);
      regWrite(REG_CTRL, 16'h0001);
      tick(2300);
      regRead(REG_DUTY, rd);
      check(rd, 16'(PER));
      regWrite(REG_TARGET, 16'h0001);
      fork
         spin(250);
         begin
            tick(600);
            regRead(REG_SPEED, rd);
            check(rd, 16'h0014);
            tick(1800);
            regRead(REG_DUTY, rd);
            check(rd, 16'h0000);
         end
      join
      regWrite(REG_TARGET, 16'hFFFF);
      adcSend(ADC_TEMP, 12'h03C);
      regWrite(REG_CTRL, 16'h0000);
      regWrite(REG_CTRL, 16'h0001);
      tick(2);
      status(8'h20);
      adcSend(ADC_TEMP, 12'h032);
      tick(2);
      status(8'h40);
      tick(600);
      adcSend(ADC_TEMP, 12'h050);
      tick(3);
      observe(g);
      check(16'(g), 16'h0000);
      status(8'h22);
      regRead(REG_TEMP, rd);
      check(rd, 16'h0050);
      adcSend(ADC_TEMP, 12'h028);
      regWrite(REG_STATUS, 16'h0010);
      tick(2);
      status(8'h40);
      regWrite(REG_VOLT_LIM, 16'h0064);
      adcSend(ADC_VOLT, 12'h065);
      tick(2);
      status(8'h24);
      regRead(REG_VOLT, rd);
      check(rd, 16'h0065);
      check(16'(shootThrough), 16'h0000);
      finish_test();
   end
endmodule
